// [ase_pkg.sv]
// Constants shared by the ALU front end: microword fields, register map, reset values
package ase_pkg;

  // Datapath geometry
  localparam int unsigned DATA_W = 16;
  localparam int unsigned AMT_W = 4;
  localparam int unsigned STK_DEPTH = 16;
  localparam int unsigned STK_AW = 4;
  localparam int unsigned MIR_W = 24;

  // Microinstruction field positions
  localparam int unsigned MIR_AMT_LSB = 8;
  localparam int unsigned MIR_AMT_MSB = 11;
  localparam int unsigned MIR_STACK_DIR = 13;
  localparam int unsigned MIR_MASK_FILL = 19;
  localparam int unsigned MIR_AMT_SRC = 20;

  // Opcode nibble forcing: bits cleared when an opcode byte goes to the ALU
  localparam int unsigned OPC_CLR_LSB = 4;
  localparam int unsigned OPC_CLR_MSB = 7;

  // Stack adder operands and reset values
  localparam logic [STK_AW-1:0] STK_E_PUSH = 4'hF;
  localparam logic [STK_AW-1:0] STK_E_IDLE = 4'h0;
  localparam logic [STK_AW-1:0] STK_PTR_RST = 4'hF;
  localparam logic [AMT_W-1:0] SHCNT_RST = 4'h0;

  // Register map, byte addresses on the AHB-Lite port
  localparam logic [7:0] REG_SHIFT_COUNT = 8'h00;
  localparam logic [7:0] REG_STACK_STATUS = 8'h04;
  localparam int unsigned ADDR_W = 8;

  // Status layout
  localparam int unsigned STAT_PTR_LSB = 0;
  localparam int unsigned STAT_EMPTY_BIT = 4;

  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ = 2'h3;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

endpackage

// [ase_front_end.sv]
// ALU front end: end-around rotator, mask fill, opcode nibble gate, evaluation stack
// Notes on behaviour
// - Rotate the 16-bit bus word end-around by 0..15; zero passes unchanged.
// - Each step moves bits toward the LSB; the bottom bit re-enters on top.
// - Two cascaded stages: 0..3 positions, then 0, 4, 8 or 12.
// - Four-bit amount: low pair drives stage one, high pair stage two.
// - Microword bit 20 high picks the count register, low picks bits 8..11.
// - Count register loads from the data bus when it is the bus destination.
// - Microword bit 19 forces the top N output bits to one, N the amount.
// - Opcode byte to the ALU keeps only its low nibble; bits 7..4 go zero.
// - Operand bus: rotator when ALU is destination, otherwise stack output.
// - Stack write data is always the slice output.
// - Sixteen 16-bit stack words; slice top register makes seventeen levels.
// - Stack grows downward: push lowers the address, pop raises it.
// - Pop reads the pointed word unmodified; pointer increments at cycle end.
// - Push when bit 13 and ALU select are low; address is pointer plus 1111.
// - Write pulse only during a push, storing slice output at decremented address.
// - Push decrements pointer at cycle end to the adder's value.
// - Empty is adder carry with carry in true; outside push means pointer 1111.
// - No overflow detection; only empty is provided.
// - Controls settle early; all state captured at the end of each microcycle.
`timescale 1ns/10ps
`default_nettype none

module ase_front_end
  import ase_pkg::*;
(
  // Clock and reset
  input wire logic CLK_I,
  input wire logic RESETN_I,
  // Microprogram control
  input wire logic [MIR_W-1:0] MICROINSTRUCTION_WORD_I,
  input wire logic ALU_BUS_DEST_SEL_N_I,
  input wire logic SHIFT_COUNT_DEST_SEL_N_I,
  input wire logic OPCODE_SOURCE_SEL_N_I,
  input wire logic STACK_OP_ENABLE_I,
  // Data paths
  input wire logic [DATA_W-1:0] DATA_BUS_I,
  input wire logic [DATA_W-1:0] SLICE_RESULT_I,
  output logic [DATA_W-1:0] DIRECT_OPERAND_BUS_O,
  output logic STACK_EMPTY_O,
  output logic STACK_WRITE_O,
  output logic [STK_AW-1:0] STACK_ADDR_O,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP
);

  // Rotate toward the LSB, bits leaving the bottom re-enter at the top
  function automatic logic [DATA_W-1:0] ase_rotr(input logic [DATA_W-1:0] x,
                                                 input logic [AMT_W-1:0] n);
    logic [2*DATA_W-1:0] dbl;
    dbl = {x, x} >> n;
    return dbl[DATA_W-1:0];
  endfunction

  // State
  logic [AMT_W-1:0] shift_count_ff, nxt_shift_count;
  logic [STK_AW-1:0] stack_ptr_ff, nxt_stack_ptr;
  logic [DATA_W-1:0] stack_mem [STK_DEPTH];
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic wr_pend_ff, nxt_wr_pend;
  logic [ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;

  // Decoded controls
  logic alu_dest;
  logic mask_fill_enable;
  logic shift_amount_source_sel;
  logic stack_direction_bit;
  logic [AMT_W-1:0] rot_amt;
  logic [DATA_W-1:0] stage1, stage2, shaped;
  logic do_push, do_pop;
  logic [STK_AW-1:0] stk_e;
  logic [STK_AW:0] adder_sum;
  logic [STK_AW:0] empty_sum;
  logic [STK_AW-1:0] stack_addr;

  assign alu_dest = ~ALU_BUS_DEST_SEL_N_I;
  assign mask_fill_enable = MICROINSTRUCTION_WORD_I[MIR_MASK_FILL];
  assign shift_amount_source_sel = MICROINSTRUCTION_WORD_I[MIR_AMT_SRC];
  assign stack_direction_bit = MICROINSTRUCTION_WORD_I[MIR_STACK_DIR];

  // Amount mux between count register and immediate field
  assign rot_amt = shift_amount_source_sel ? shift_count_ff :
                   MICROINSTRUCTION_WORD_I[MIR_AMT_MSB:MIR_AMT_LSB];

  // Two cascaded rotate stages; fine pair first, groups of four second
  always_comb begin
    stage1 = ase_rotr(DATA_BUS_I, {2'b00, rot_amt[1:0]});
    stage2 = ase_rotr(stage1, {rot_amt[3:2], 2'b00});
    shaped = stage2;
    if (mask_fill_enable) begin
      // Top N bits set from the MSB end; N of zero leaves data alone
      shaped = stage2 | ~({DATA_W{1'b1}} >> rot_amt);
    end
    if (!OPCODE_SOURCE_SEL_N_I && alu_dest) begin
      shaped[OPC_CLR_MSB:OPC_CLR_LSB] = '0;
    end
  end

  // Stack operation decode; bit 13 high means no stack traffic
  assign do_push = STACK_OP_ENABLE_I && !stack_direction_bit && alu_dest;
  assign do_pop = STACK_OP_ENABLE_I && !stack_direction_bit && !alu_dest;

  // Address adder: E operand is 1111 only during push, so push sees pointer-1
  always_comb begin
    stk_e = do_push ? STK_E_PUSH : STK_E_IDLE;
    adder_sum = {1'b0, stack_ptr_ff} + {1'b0, stk_e};
    stack_addr = adder_sum[STK_AW-1:0];
    // Carry out with carry in true; only pointer 1111 carries outside a push
    empty_sum = {1'b0, stack_ptr_ff} + {1'b0, stk_e} + {{STK_AW{1'b0}}, 1'b1};
  end

  // Operand bus: rotator for ALU destination, else the stack word (unmodified)
  assign DIRECT_OPERAND_BUS_O = alu_dest ? shaped : stack_mem[stack_addr];
  assign STACK_EMPTY_O = empty_sum[STK_AW];
  // No overflow flag: pointer simply wraps
  assign STACK_WRITE_O = do_push;
  assign STACK_ADDR_O = stack_addr;

  // Next pointer: wraps modulo 16 on both directions
  always_comb begin
    nxt_stack_ptr = stack_ptr_ff;
    if (do_push) begin
      nxt_stack_ptr = adder_sum[STK_AW-1:0];
    end else if (do_pop) begin
      nxt_stack_ptr = stack_ptr_ff + 4'h1;
    end
  end

  // Pointer register, captured at the end of the microcycle
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      stack_ptr_ff <= STK_PTR_RST;
    end else begin
      stack_ptr_ff <= nxt_stack_ptr;
    end
  end

  // Stack storage; write data is the slice output regardless of bus owner
  always_ff @(posedge CLK_I) begin
    if (do_push) begin
      stack_mem[stack_addr] <= SLICE_RESULT_I;
    end
  end

  // AHB-Lite address phase qualification
  logic ahb_take;
  logic ahb_word_ok;
  assign ahb_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ || HTRANS == HTRANS_SEQ);
  assign ahb_word_ok = HSIZE == HSIZE_WORD;

  // Bus next state: read data latched at the address phase, write at data phase
  always_comb begin
    nxt_hrdata = hrdata_ff;
    nxt_wr_pend = 1'b0;
    nxt_wr_addr = wr_addr_ff;
    if (ahb_take) begin
      nxt_hrdata = '0;
      if (HWRITE) begin
        nxt_wr_pend = ahb_word_ok;
        nxt_wr_addr = HADDR[ADDR_W-1:0];
      end else begin
        unique case (HADDR[ADDR_W-1:0])
          REG_SHIFT_COUNT: nxt_hrdata[AMT_W-1:0] = shift_count_ff;
          REG_STACK_STATUS: begin
            nxt_hrdata[STAT_PTR_LSB +: STK_AW] = stack_ptr_ff;
            nxt_hrdata[STAT_EMPTY_BIT] = STACK_EMPTY_O;
          end
          default: nxt_hrdata = '0;
        endcase
      end
    end
  end

  // Count register: microcode load wins over a same-cycle software write
  always_comb begin
    nxt_shift_count = shift_count_ff;
    if (wr_pend_ff && wr_addr_ff == REG_SHIFT_COUNT) begin
      nxt_shift_count = HWDATA[AMT_W-1:0];
    end
    if (!SHIFT_COUNT_DEST_SEL_N_I) begin
      nxt_shift_count = DATA_BUS_I[AMT_W-1:0];
    end
  end

  // Register bank
  always_ff @(posedge CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      shift_count_ff <= SHCNT_RST;
      hrdata_ff <= '0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
    end else begin
      shift_count_ff <= nxt_shift_count;
      hrdata_ff <= nxt_hrdata;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
    end
  end

  // Zero wait states, always OKAY
  assign HRDATA = hrdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;

  // Helper: reference rotation from the raw formula
  logic [2*DATA_W-1:0] ref_dbl;
  assign ref_dbl = {DATA_BUS_I, DATA_BUS_I} >> rot_amt;

  // Helper: per-stage references, so a miswired select pair shows up on its own
  logic [2*DATA_W-1:0] ref_fine_dbl;
  logic [2*DATA_W-1:0] ref_coarse_dbl;
  assign ref_fine_dbl = {DATA_BUS_I, DATA_BUS_I} >> rot_amt[1:0];
  assign ref_coarse_dbl = {stage1, stage1} >> {rot_amt[3:2], 2'b00};

  a_rotate_exact: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && !mask_fill_enable && OPCODE_SOURCE_SEL_N_I) |->
      DIRECT_OPERAND_BUS_O == ref_dbl[DATA_W-1:0])
    else $error("rotator output wrong");

  a_zero_passes: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && rot_amt == 4'h0 && OPCODE_SOURCE_SEL_N_I) |->
      DIRECT_OPERAND_BUS_O == DATA_BUS_I)
    else $error("zero rotate altered data");

  a_mask_top_ones: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && mask_fill_enable && OPCODE_SOURCE_SEL_N_I && DATA_BUS_I == 16'h0000
     && rot_amt == 4'h7) |-> DIRECT_OPERAND_BUS_O == 16'hFE00)
    else $error("mask fill wrong");

  a_opcode_nibble: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && !OPCODE_SOURCE_SEL_N_I) |->
      DIRECT_OPERAND_BUS_O[OPC_CLR_MSB:OPC_CLR_LSB] == 4'h0)
    else $error("opcode upper nibble not cleared");

  a_count_load: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !SHIFT_COUNT_DEST_SEL_N_I |=> shift_count_ff == $past(DATA_BUS_I[AMT_W-1:0]))
    else $error("count register did not load");

  a_push_then_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_push ##1 !alu_dest |->
      DIRECT_OPERAND_BUS_O == $past(SLICE_RESULT_I))
    else $error("pushed word not on top");

  a_push_ptr_dec: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_push |=> stack_ptr_ff == $past(stack_ptr_ff) - 4'h1)
    else $error("push did not decrement pointer");

  a_pop_ptr_inc: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_pop |-> (STACK_ADDR_O == stack_ptr_ff) ##1 stack_ptr_ff == $past(stack_ptr_ff) + 4'h1)
    else $error("pop address or increment wrong");

  a_write_only_push: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    STACK_WRITE_O |-> (STACK_OP_ENABLE_I && alu_dest && !stack_direction_bit))
    else $error("write pulse outside push");

  a_empty_flag: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !do_push |-> STACK_EMPTY_O == (stack_ptr_ff == 4'hF))
    else $error("empty flag wrong");

  // Rotator stages checked one at a time
  a_stage_fine: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    stage1 == ref_fine_dbl[DATA_W-1:0])
    else $error("first rotate stage wrong");

  a_stage_coarse: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    stage2 == ref_coarse_dbl[DATA_W-1:0])
    else $error("second rotate stage wrong");

  a_lsb_reenters: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && !mask_fill_enable && OPCODE_SOURCE_SEL_N_I && rot_amt == 4'h1) |->
      DIRECT_OPERAND_BUS_O == {DATA_BUS_I[0], DATA_BUS_I[DATA_W-1:1]})
    else $error("bottom bit did not re-enter on top");

  a_rot_by_eight: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && !mask_fill_enable && OPCODE_SOURCE_SEL_N_I && rot_amt == 4'h8) |->
      DIRECT_OPERAND_BUS_O == {DATA_BUS_I[DATA_W/2-1:0], DATA_BUS_I[DATA_W-1:DATA_W/2]})
    else $error("rotate by eight wrong");

  // Mask fill: top bits only when the microword asks for it
  a_mask_full: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && mask_fill_enable && OPCODE_SOURCE_SEL_N_I && rot_amt == 4'hF) |->
      DIRECT_OPERAND_BUS_O[DATA_W-1:1] == '1)
    else $error("full mask not generated");

  a_no_fill_off: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && !mask_fill_enable && OPCODE_SOURCE_SEL_N_I && DATA_BUS_I == '0) |->
      DIRECT_OPERAND_BUS_O == '0)
    else $error("ones appeared without mask fill");

  // Opcode gate: low nibble and upper byte pass, bits 7..4 cleared
  a_opcode_low_kept: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && !OPCODE_SOURCE_SEL_N_I && !mask_fill_enable && rot_amt == 4'h0) |->
      DIRECT_OPERAND_BUS_O[OPC_CLR_LSB-1:0] == DATA_BUS_I[OPC_CLR_LSB-1:0])
    else $error("opcode low nibble lost");

  a_opcode_high_pass: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (alu_dest && !OPCODE_SOURCE_SEL_N_I && !mask_fill_enable && rot_amt == 4'h0) |->
      DIRECT_OPERAND_BUS_O[DATA_W-1:OPC_CLR_MSB+1] == DATA_BUS_I[DATA_W-1:OPC_CLR_MSB+1])
    else $error("opcode gate touched upper byte");

  // Amount source selection
  a_amt_from_field: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    !shift_amount_source_sel |->
      rot_amt == MICROINSTRUCTION_WORD_I[MIR_AMT_MSB:MIR_AMT_LSB])
    else $error("immediate amount not used");

  a_amt_from_count: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    shift_amount_source_sel |-> rot_amt == shift_count_ff)
    else $error("count register amount not used");

  a_shifter_drives_bus: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    alu_dest |-> DIRECT_OPERAND_BUS_O == shaped)
    else $error("operand bus not from rotator");

  // Push side of the stack
  a_push_write_data: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_push |=> stack_mem[$past(stack_addr)] == $past(SLICE_RESULT_I))
    else $error("slice output not stored on push");

  a_push_addr_below: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_push |-> STACK_ADDR_O == stack_ptr_ff - 4'h1)
    else $error("push address not below pointer");

  a_push_new_top: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_push |=> stack_ptr_ff == $past(STACK_ADDR_O))
    else $error("pointer not at pushed word");

  a_push_write_pulse: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_push |-> STACK_WRITE_O)
    else $error("push without write pulse");

  a_push_empty_set: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    do_push |-> STACK_EMPTY_O)
    else $error("adder carry missing during push");

  // Pointer holds without a stack operation and wraps past the top
  a_idle_ptr_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (!do_push && !do_pop) |=> stack_ptr_ff == $past(stack_ptr_ff))
    else $error("pointer moved without stack op");

  a_pop_ptr_wrap: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (do_pop && stack_ptr_ff == STK_PTR_RST) |=> stack_ptr_ff == '0)
    else $error("pointer did not wrap");

  // Count register: holds unless loaded by microcode or software
  a_count_hold: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (SHIFT_COUNT_DEST_SEL_N_I && !(wr_pend_ff && wr_addr_ff == REG_SHIFT_COUNT)) |=>
      shift_count_ff == $past(shift_count_ff))
    else $error("count register changed unasked");

  a_sw_count_load: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (wr_pend_ff && wr_addr_ff == REG_SHIFT_COUNT && SHIFT_COUNT_DEST_SEL_N_I) |=>
      shift_count_ff == $past(HWDATA[AMT_W-1:0]))
    else $error("software count write lost");

  a_status_read: assert property (@(posedge CLK_I) disable iff (!RESETN_I)
    (ahb_take && !HWRITE && HADDR[ADDR_W-1:0] == REG_STACK_STATUS) |=>
      (HRDATA[STAT_EMPTY_BIT] == $past(STACK_EMPTY_O)
       && HRDATA[STAT_PTR_LSB +: STK_AW] == $past(stack_ptr_ff)))
    else $error("status read data wrong");

endmodule

`default_nettype wire

// [ase_mcu_model.sv]
// Microprogram control model: destination forcing and empty sampling
`timescale 1ns/10ps
`default_nettype none
module ase_mcu_model (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rstn_i,
  // Requests from the bench
  input wire logic imm_i,
  input wire logic alu_n_i,
  input wire logic stack_op_i,
  // Front end side
  input wire logic empty_i,
  output logic alu_n_o,
  output logic empty_seen_o
);
  // Immediate constants make the ALU the implicit destination
  assign alu_n_o = imm_i ? 1'b0 : alu_n_i;
  // Flag is garbage during a push; it is sampled only when stack ops are off
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      empty_seen_o <= 1'b0;
    end else if (!stack_op_i) begin
      empty_seen_o <= empty_i;
    end
  end
endmodule
`default_nettype wire

// [tb_alu_shifter_eval_stack.sv]
// Self-checking bench for the ALU front end
`timescale 1ns/10ps
`default_nettype none
module tb_alu_shifter_eval_stack;
  import ase_pkg::*;
  // Stimulus and observed signals
  logic clk = 1'b0, rstn = 1'b0, imm = 1'b0, alu_req_n = 1'b1;
  logic sc_n = 1'b1, op_n = 1'b1, en = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [MIR_W-1:0] microinstruction_word = '0;
  logic [DATA_W-1:0] dbus = '0, slice = '0, dob;
  logic alu_n, empty, wr, seen, hready, hresp;
  logic [STK_AW-1:0] addr;
  logic [31:0] haddr = '0, hwdata = '0, hrdata;
  logic [1:0] htrans = 2'h0;
  int err_count = 0, check_count = 0;
  always #2 clk = ~clk;
  ase_front_end DUT (.CLK_I(clk), .RESETN_I(rstn), .MICROINSTRUCTION_WORD_I(microinstruction_word),
    .ALU_BUS_DEST_SEL_N_I(alu_n), .SHIFT_COUNT_DEST_SEL_N_I(sc_n),
    .OPCODE_SOURCE_SEL_N_I(op_n), .STACK_OP_ENABLE_I(en), .DATA_BUS_I(dbus),
    .SLICE_RESULT_I(slice), .DIRECT_OPERAND_BUS_O(dob), .STACK_EMPTY_O(empty),
    .STACK_WRITE_O(wr), .STACK_ADDR_O(addr), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(HSIZE_WORD), .HWDATA(hwdata),
    .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp));
  ase_mcu_model mcu (.clk_i(clk), .rstn_i(rstn), .imm_i(imm), .alu_n_i(alu_req_n),
    .stack_op_i(en), .empty_i(empty), .alu_n_o(alu_n), .empty_seen_o(seen));
  // Compare and count
  task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Microword builder
  function automatic logic [MIR_W-1:0] mw(logic src, logic msk, logic dir, logic [3:0] n);
    mw = '0;
    mw[MIR_AMT_SRC] = src;
    mw[MIR_MASK_FILL] = msk;
    mw[MIR_STACK_DIR] = dir;
    mw[MIR_AMT_MSB:MIR_AMT_LSB] = n;
  endfunction
  // Reference rotate toward the LSB, optional top fill
  function automatic logic [15:0] rot(logic [15:0] d, logic [3:0] n, logic m);
    rot = (d >> n) | (d << (5'd16 - n));
    if (m) rot = rot | ~(16'hFFFF >> n);
  endfunction
  // One microcycle; outputs settle 1 ns after the edge
  task automatic cyc(logic [MIR_W-1:0] m, logic i, logic a, logic s, logic o, logic e,
                     logic [15:0] d, logic [15:0] sl);
    @(posedge clk);
    microinstruction_word <= m;
    imm <= i;
    alu_req_n <= a;
    sc_n <= s;
    op_n <= o;
    en <= e;
    dbus <= d;
    slice <= sl;
    #1;
  endtask
  // Single word AHB-Lite transfer, waits on the ready handshake
  task automatic ahb(logic w, logic [31:0] a, logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, hresp);
    hsel <= 1'b0;
  endtask
  task automatic t_reset();
    logic [31:0] r;
    cyc(mw(0, 0, 1, 0), 0, 1, 1, 1, 0, 16'h0000, 16'h0000);
    chk("empty", 32'h1, empty);
    ahb(1'b0, 32'h4, 32'h0, r);
    chk("status", 32'h1F, r);
    ahb(1'b0, 32'h40, 32'h0, r);
    chk("unmapped", 32'h0, r);
    $display("test reset done");
  endtask
  task automatic t_rotate();
    for (int k = 0; k < 32; k++) begin
      cyc(mw(0, k[4], 1, k[3:0]), 0, 0, 1, 1, 0, 16'hB2C1, 16'h0000);
      chk("rotate", rot(16'hB2C1, k[3:0], k[4]), dob);
    end
    for (int j = 0; j < 2; j++) begin
      cyc(mw(0, j[0], 1, 4'h7), 0, 0, 1, 1, 0, 16'h0000, 16'h0000);
      chk("mask", j[0] ? 32'hFE00 : 32'h0, dob);
    end
    $display("test rotate done");
  endtask
  task automatic t_count();
    logic [31:0] r;
    cyc(mw(0, 0, 1, 0), 0, 1, 0, 1, 0, 16'h0009, 16'h0000);
    cyc(mw(1, 0, 1, 3), 0, 0, 1, 1, 0, 16'hB2C1, 16'h0000);
    chk("count src", rot(16'hB2C1, 9, 0), dob);
    ahb(1'b1, 32'h0, 32'h5, r);
    ahb(1'b0, 32'h0, 32'h0, r);
    chk("count reg", 32'h5, r);
    cyc(mw(1, 0, 1, 3), 0, 0, 1, 1, 0, 16'hB2C1, 16'h0000);
    chk("count hold", rot(16'hB2C1, 5, 0), dob);
    $display("test count done");
  endtask
  task automatic t_opcode();
    cyc(mw(0, 0, 1, 0), 0, 0, 1, 0, 0, 16'h00B7, 16'h0000);
    chk("opcode", 32'h7, dob);
    cyc(mw(0, 0, 1, 0), 1, 1, 1, 1, 0, 16'h1234, 16'h0000);
    chk("immediate", 32'h1234, dob);
    $display("test opcode done");
  endtask
  task automatic t_stack();
    logic [15:0] v [3] = '{16'hA1A1, 16'hB2B2, 16'hC3C3};
    for (int i = 0; i < 3; i++) begin
      cyc(mw(0, 0, 0, 0), 0, 0, 1, 1, 1, 16'h5A5A, v[i]);
      chk("push wr", 32'h1, wr);
      chk("push addr", 32'hE - i, addr);
      chk("push bus", 32'h5A5A, dob);
    end
    cyc(mw(0, 0, 1, 0), 0, 1, 1, 1, 1, 16'h0000, 16'h0000);
    chk("idle wr", 32'h0, wr);
    chk("idle addr", 32'hC, addr);
    chk("not empty", 32'h0, empty);
    chk("top word", v[2], dob);
    for (int i = 0; i < 3; i++) begin
      cyc(mw(0, 0, 0, 0), 0, 1, 1, 1, 1, 16'h0000, 16'h0000);
      chk("pop data", v[2 - i], dob);
      chk("pop addr", 32'hC + i, addr);
    end
    cyc(mw(0, 0, 1, 0), 0, 1, 1, 1, 0, 16'h0000, 16'h0000);
    chk("empty", 32'h1, empty);
    cyc(mw(0, 0, 0, 0), 0, 1, 1, 1, 1, 16'h0000, 16'h0000);
    chk("seen", 32'h1, seen);
    cyc(mw(0, 0, 1, 0), 0, 1, 1, 1, 0, 16'h0000, 16'h0000);
    chk("wrap", 32'h0, addr);
    cyc(mw(0, 0, 1, 0), 0, 1, 1, 1, 0, 16'h0000, 16'h0000);
    chk("seen clear", 32'h0, seen);
    $display("test stack done");
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    t_reset();
    t_rotate();
    t_count();
    t_opcode();
    t_stack();
    test_done();
  end
  // Watchdog, about twenty times the expected run
  initial begin
    #(4 * 1500);
    err_count++;
    test_done();
  end
endmodule
`default_nettype wire
